// ===== ccic_pkg.sv
// ccic_pkg: register map, field layout, reset values and timing constants for the control link / i2c block
// assumes a 100 MHz block clock; every block of this family imports nothing and uses ccic_pkg::name
`default_nettype none
package ccic_pkg;
  localparam int CLK_PERIOD_NS = 10;
  // register offsets (8-bit register space)
  localparam logic [7:0] ADDR_LINK_WD   = 8'h04;
  localparam logic [7:0] ADDR_I2C_TIME  = 8'h05;
  localparam logic [7:0] ADDR_I2C_PROT  = 8'h06;
  // reset values
  localparam logic [7:0] RST_LINK_WD    = 8'hFE;
  localparam logic [7:0] RST_I2C_TIME   = 8'h1E;
  localparam logic [7:0] RST_I2C_PROT   = 8'h00;
  // field positions
  localparam int WD_TMO_LSB    = 1;
  localparam int WD_TMO_MSB    = 7;
  localparam int WD_OFF_BIT    = 0;
  localparam int FWD_ALL_BIT   = 7;
  localparam int HOLD_LSB      = 4;
  localparam int HOLD_MSB      = 6;
  localparam int FILT_LSB      = 0;
  localparam int FILT_MSB      = 3;
  localparam int SEQ_ERR_BIT   = 7;
  localparam int SEQ_CLR_BIT   = 6;
  localparam int ODLY_LSB      = 3;
  localparam int ODLY_MSB      = 4;
  localparam int LWD_BIT       = 2;
  localparam int BUS_FAST_BIT  = 1;
  localparam int BUS_OFF_BIT   = 0;
  // timing
  localparam int TXN_UNIT_MS   = 2;
  localparam int TXN_UNIT_CYC  = TXN_UNIT_MS * 1000000 / CLK_PERIOD_NS;
  localparam int BUS_FAST_US   = 50;
  localparam int BUS_FAST_CYC  = BUS_FAST_US * 1000 / CLK_PERIOD_NS;
  localparam int BUS_SLOW_S    = 1;
  localparam int BUS_SLOW_CYC  = BUS_SLOW_S * 1000000000 / CLK_PERIOD_NS;
  localparam int HOLD_STEP_NS  = 50;
  localparam int HOLD_STEP_CYC = (HOLD_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FILT_STEP_NS  = 5;
  localparam int ODLY_BASE_NS  = 250;
  localparam int ODLY_STEP_NS  = 50;
  localparam int CLR_HALF_NS   = 5000;
  localparam int CLR_HALF_CYC  = CLR_HALF_NS / CLK_PERIOD_NS;
  localparam int CLR_PULSES    = 9;
endpackage : ccic_pkg
`default_nettype wire

// ===== ccic_glitch_filt.sv
// ccic_glitch_filt: two-flop synchroniser followed by a programmable glitch rejecter for one i2c line
// assumes the pin is asynchronous to ref_clk_i; idle level of an i2c line is high
`default_nettype none
module ccic_glitch_filt #(
  parameter int DEPTH_W = 4
) (
  input  wire logic               ref_clk_i,
  input  wire logic               sys_rst_i,
  input  wire logic               pin_i,
  input  wire logic [DEPTH_W-1:0] depth_i,
  output logic                    level_o
);
  logic               sync1;
  logic               sync2;
  logic [DEPTH_W:0]   run;
  logic [DEPTH_W:0]   limit;
  logic [DEPTH_W+7:0] span;

  if (DEPTH_W < 1) begin : g_bad_depth
    $error("ccic_glitch_filt: DEPTH_W must be at least 1");
  end

  // depth is in 5 ns steps; a 10 ns clock rejects up to ceil(depth*5/10) samples
  // worked out wide so that the deepest setting cannot wrap before the divide
  assign span  = ({8'h00, depth_i} * (DEPTH_W+8)'(ccic_pkg::FILT_STEP_NS)
                  + (DEPTH_W+8)'(ccic_pkg::CLK_PERIOD_NS - 1))
                 / (DEPTH_W+8)'(ccic_pkg::CLK_PERIOD_NS);
  assign limit = span[DEPTH_W:0];

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      sync1 <= 1'b1;
      sync2 <= 1'b1;
    end else begin
      sync1 <= pin_i;
      sync2 <= sync1;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      run     <= '0;
      level_o <= 1'b1;
    end else if (sync2 == level_o) begin
      run <= '0;
    end else if (run >= limit) begin
      level_o <= sync2; // R7
      run     <= '0;
    end else begin
      run <= run + 1'b1;
    end
  end
endmodule : ccic_glitch_filt
`default_nettype wire

// ===== ccic_top.sv
// ccic_top: control link watchdog, i2c timing controls, remote write protection and i2c bus watchdog
// assumes register accesses and link transaction events come from logic on ref_clk_i; pins and the
// link clock are asynchronous and are synchronised here
// Overview of operation
// R1 - seven-bit link timeout field in bits 7:1, 2 ms units, resets to 7Fh.
// R2 - watchdog enabled aborts a link transaction that outlives the programmed timeout.
// R3 - software must never program the link timeout field with zero.
// R4 - bit 0 set stops the link watchdog, clear allows it, resets clear.
// R5 - bit 7 set forwards every i2c transaction across the link, resets clear.
// R6 - bits 6:4 set internal sda hold after scl in 50 ns steps, reset 1.
// R7 - bits 3:0 set widest rejected scl/sda glitch in 5 ns steps, reset Eh.
// R8 - read-only bit 7 flags a forward link sequence error.
// R9 - writing one to bit 6 clears the sequence error flag.
// R10 - bits 4:3 pick scl to sda output delay, 250 to 400 ns.
// R11 - bit 2 set refuses register writes arriving over the link from remote master.
// R12 - remote access to local i2c slaves stays allowed regardless of bit 2.
// R13 - bit 1 picks bus watchdog expiry: about 50 us set, about 1 s clear.
// R14 - bus watchdog detects free or hung bus; bit 0 set disables it.
// R15 - sda high and bus quiet for the period means the bus is free.
// R16 - sda low and bus quiet for the period drives nine scl pulses.
// R17 - clear bit held at one keeps the error flag at zero.
`default_nettype none
module ccic_top #(
  parameter int TXN_UNIT_CYC = ccic_pkg::TXN_UNIT_CYC,
  parameter int BUS_FAST_CYC = ccic_pkg::BUS_FAST_CYC,
  parameter int BUS_SLOW_CYC = ccic_pkg::BUS_SLOW_CYC
) (
  input  wire logic       ref_clk_i,
  input  wire logic       sys_rst_i,
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  input  wire logic       reg_remote_i,
  input  wire logic [7:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  output logic      [7:0] reg_rdata_o,
  output logic            reg_wr_refused_o,
  input  wire logic       remote_slave_req_i,
  output logic            remote_slave_pass_o,
  input  wire logic       txn_start_i,
  input  wire logic       txn_done_i,
  output logic            txn_abort_o,
  input  wire logic       link_clk_i,
  input  wire logic       link_seq_err_i,
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            scl_o,
  output logic            scl_oe_o,
  output logic            sda_held_o,
  output logic            fwd_all_o,
  output logic      [8:0] sda_out_dly_ns_o,
  output logic            bus_free_o,
  output logic            bus_clear_busy_o
);
  localparam int TXN_W = $clog2(TXN_UNIT_CYC + 1);
  localparam int BUS_W = $clog2(BUS_SLOW_CYC + 1);
  localparam int HOLD_TAPS = 7 * ccic_pkg::HOLD_STEP_CYC + 1;

  generate
    if (TXN_UNIT_CYC < 1 || BUS_FAST_CYC < 1 || BUS_SLOW_CYC < BUS_FAST_CYC) begin : g_bad_param
      $error("ccic_top: timing parameters out of range");
    end
  endgenerate

  typedef enum logic [2:0] {
    CCIC_CLR_IDLE = 3'b001,
    CCIC_CLR_LOW  = 3'b010,
    CCIC_CLR_HIGH = 3'b100
  } ccic_clr_t;

  logic [7:0]       link_wd;
  logic [7:0]       i2c_time;
  logic [6:0]       i2c_prot;
  logic             seq_err;
  logic             wr_ok;
  logic             lc_s1, lc_s2, lc_s3;
  logic             le_s1, le_s2;
  logic             seq_evt;
  logic             txn_active;
  logic [TXN_W-1:0] prescale;
  logic [7:0]       units;
  logic             unit_tick;
  logic             scl_f, sda_f, scl_q, sda_q;
  logic [1:0]       line_f;
  logic             bus_act;
  logic [BUS_W-1:0] idle_cnt;
  logic [BUS_W-1:0] idle_lim;
  logic             idle_exp;
  logic [HOLD_TAPS-1:0] hold_line;
  ccic_clr_t        clr_st;
  logic [15:0]      half_cnt;
  logic [3:0]       pulses;

  function automatic logic wr_hit(input logic [7:0] a, input logic [7:0] target);
    wr_hit = (a == target);
  endfunction : wr_hit

  // register write path; writes from a remote master can be locked out
  assign wr_ok = reg_wr_i && !(reg_remote_i && i2c_prot[ccic_pkg::LWD_BIT]); // R11

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      link_wd  <= ccic_pkg::RST_LINK_WD; // R1
      i2c_time <= ccic_pkg::RST_I2C_TIME; // R6
      i2c_prot <= ccic_pkg::RST_I2C_PROT[6:0];
    end else if (wr_ok) begin
      if (wr_hit(reg_addr_i, ccic_pkg::ADDR_LINK_WD)) begin
        link_wd <= reg_wdata_i; // R4
      end else if (wr_hit(reg_addr_i, ccic_pkg::ADDR_I2C_TIME)) begin
        i2c_time <= reg_wdata_i; // R5
      end else if (wr_hit(reg_addr_i, ccic_pkg::ADDR_I2C_PROT)) begin
        i2c_prot <= {reg_wdata_i[6], 1'b0, reg_wdata_i[4:0]}; // R9
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      reg_wr_refused_o <= 1'b0;
    end else begin
      reg_wr_refused_o <= reg_wr_i && !wr_ok; // R11
    end
  end

  // slave traffic is not a register write, so the lockout never gates it
  assign remote_slave_pass_o = remote_slave_req_i; // R12

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      if (reg_addr_i == ccic_pkg::ADDR_LINK_WD) begin
        reg_rdata_o <= link_wd;
      end else if (reg_addr_i == ccic_pkg::ADDR_I2C_TIME) begin
        reg_rdata_o <= i2c_time;
      end else if (reg_addr_i == ccic_pkg::ADDR_I2C_PROT) begin
        reg_rdata_o <= {seq_err, i2c_prot}; // R8
      end else begin
        reg_rdata_o <= 8'h00;
      end
    end
  end

  // link clock and error level are sampled, never used as a clock
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      lc_s1 <= 1'b0;
      lc_s2 <= 1'b0;
      lc_s3 <= 1'b0;
      le_s1 <= 1'b0;
      le_s2 <= 1'b0;
    end else begin
      lc_s1 <= link_clk_i;
      lc_s2 <= lc_s1;
      lc_s3 <= lc_s2;
      le_s1 <= link_seq_err_i;
      le_s2 <= le_s1;
    end
  end

  assign seq_evt = lc_s2 && !lc_s3 && le_s2;

  // the clear bit is a level: while it stays set, new errors are held off
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      seq_err <= 1'b0;
    end else if (i2c_prot[ccic_pkg::SEQ_CLR_BIT]) begin
      seq_err <= 1'b0; // R17
    end else if (seq_evt) begin
      seq_err <= 1'b1; // R8
    end
  end

  // link transaction watchdog; a zero timeout never matches and so never aborts
  assign unit_tick = (prescale == TXN_W'(TXN_UNIT_CYC - 1));

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      txn_active  <= 1'b0;
      prescale    <= '0;
      units       <= 8'h00;
      txn_abort_o <= 1'b0;
    end else begin
      txn_abort_o <= 1'b0;
      if (txn_done_i || link_wd[ccic_pkg::WD_OFF_BIT]) begin
        txn_active <= 1'b0; // R4
        prescale   <= '0;
        units      <= 8'h00;
      end else if (txn_start_i && !txn_active) begin
        txn_active <= 1'b1;
        prescale   <= '0;
        units      <= 8'h00;
      end else if (txn_active) begin
        prescale <= unit_tick ? '0 : prescale + 1'b1;
        if (unit_tick) begin
          units <= units + 8'h01;
          if ({1'b0, units} + 9'h001 == {2'b00, link_wd[ccic_pkg::WD_TMO_MSB:ccic_pkg::WD_TMO_LSB]}) begin
            txn_abort_o <= 1'b1; // R2
            txn_active  <= 1'b0;
          end
        end
      end
    end
  end

  // glitch filters on both lines
  for (genvar g = 0; g < 2; g++) begin : g_filt
    ccic_glitch_filt #(.DEPTH_W(4)) u_filt (
      .ref_clk_i (ref_clk_i),
      .sys_rst_i (sys_rst_i),
      .pin_i     (g == 0 ? scl_i : sda_i),
      .depth_i   (i2c_time[ccic_pkg::FILT_MSB:ccic_pkg::FILT_LSB]), // R7
      .level_o   (line_f[g])
    );
  end
  assign scl_f = line_f[0];
  assign sda_f = line_f[1];

  // sda hold: a tapped delay line, 5 cycles per 50 ns step
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      hold_line <= '1;
    end else begin
      hold_line <= {hold_line[HOLD_TAPS-2:0], sda_f};
    end
  end

  assign sda_held_o = (i2c_time[ccic_pkg::HOLD_MSB:ccic_pkg::HOLD_LSB] == 3'h0) ? sda_f :
                      hold_line[int'(i2c_time[ccic_pkg::HOLD_MSB:ccic_pkg::HOLD_LSB]) *
                                ccic_pkg::HOLD_STEP_CYC - 1]; // R6

  assign fwd_all_o        = i2c_time[ccic_pkg::FWD_ALL_BIT]; // R5
  assign sda_out_dly_ns_o = 9'(ccic_pkg::ODLY_BASE_NS) +
                            9'(ccic_pkg::ODLY_STEP_NS) * {7'h00, i2c_prot[ccic_pkg::ODLY_MSB:ccic_pkg::ODLY_LSB]}; // R10

  // bus watchdog: any edge on either filtered line restarts the quiet timer
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_f;
      sda_q <= sda_f;
    end
  end

  assign bus_act  = (scl_f != scl_q) || (sda_f != sda_q) || (clr_st != CCIC_CLR_IDLE);
  assign idle_lim = i2c_prot[ccic_pkg::BUS_FAST_BIT] ? BUS_W'(BUS_FAST_CYC - 1) : BUS_W'(BUS_SLOW_CYC - 1); // R13
  assign idle_exp = !i2c_prot[ccic_pkg::BUS_OFF_BIT] && !bus_act && (idle_cnt == idle_lim); // R14

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      idle_cnt <= '0;
    end else if (bus_act || i2c_prot[ccic_pkg::BUS_OFF_BIT] || idle_exp) begin
      idle_cnt <= '0;
    end else begin
      idle_cnt <= idle_cnt + 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      bus_free_o <= 1'b0;
    end else begin
      bus_free_o <= idle_exp && sda_f; // R15
    end
  end

  // bus clear: open-drain scl, pulled low for half a period then released, nine times
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      clr_st   <= CCIC_CLR_IDLE;
      half_cnt <= 16'h0000;
      pulses   <= 4'h0;
    end else begin
      case (clr_st)
        CCIC_CLR_IDLE: begin
          half_cnt <= 16'h0000;
          pulses   <= 4'h0;
          if (idle_exp && !sda_f) begin
            clr_st <= CCIC_CLR_LOW; // R16
          end
        end
        CCIC_CLR_LOW: begin
          half_cnt <= half_cnt + 16'h0001;
          if (half_cnt == 16'(ccic_pkg::CLR_HALF_CYC - 1)) begin
            half_cnt <= 16'h0000;
            clr_st   <= CCIC_CLR_HIGH;
          end
        end
        CCIC_CLR_HIGH: begin
          half_cnt <= half_cnt + 16'h0001;
          if (half_cnt == 16'(ccic_pkg::CLR_HALF_CYC - 1)) begin
            half_cnt <= 16'h0000;
            pulses   <= pulses + 4'h1;
            clr_st   <= (pulses == 4'(ccic_pkg::CLR_PULSES - 1)) ? CCIC_CLR_IDLE : CCIC_CLR_LOW; // R16
          end
        end
        default: begin
          clr_st <= CCIC_CLR_IDLE;
        end
      endcase
    end
  end

  assign scl_o            = 1'b0;
  assign scl_oe_o         = (clr_st == CCIC_CLR_LOW);
  assign bus_clear_busy_o = (clr_st != CCIC_CLR_IDLE);

  // checks
  property p_wd_reset;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      $fell(sys_rst_i) |-> (link_wd == ccic_pkg::RST_LINK_WD) && (i2c_time == ccic_pkg::RST_I2C_TIME);
  endproperty
  a_wd_reset: assert property (p_wd_reset) else $error("reset values wrong"); // R1

  property p_abort_cause;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      txn_abort_o |-> $past(txn_active) && $past(unit_tick) && !$past(link_wd[0]);
  endproperty
  a_abort_cause: assert property (p_abort_cause) else $error("abort without expired transaction"); // R2

  property p_wd_off;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      link_wd[0] |=> !txn_abort_o && !txn_active;
  endproperty
  a_wd_off: assert property (p_wd_off) else $error("watchdog acted while disabled"); // R4

  property p_fwd_all;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      wr_ok && (reg_addr_i == ccic_pkg::ADDR_I2C_TIME) |=> (fwd_all_o == $past(reg_wdata_i[7]));
  endproperty
  a_fwd_all: assert property (p_fwd_all) else $error("forward-all bit not applied"); // R5

  property p_seq_set;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      seq_evt && !i2c_prot[6] |=> seq_err;
  endproperty
  a_seq_set: assert property (p_seq_set) else $error("sequence error lost"); // R8

  property p_seq_clr;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      i2c_prot[6] |=> !seq_err;
  endproperty
  a_seq_clr: assert property (p_seq_clr) else $error("sequence error not held clear"); // R17

  property p_lock;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      reg_wr_i && reg_remote_i && i2c_prot[2] |=> reg_wr_refused_o && $stable(link_wd) && $stable(i2c_time);
  endproperty
  a_lock: assert property (p_lock) else $error("remote write not refused"); // R11

  property p_free;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      bus_free_o |-> $past(sda_f) && $past(idle_cnt == idle_lim) && !$past(i2c_prot[0]);
  endproperty
  a_free: assert property (p_free) else $error("bus free without quiet period"); // R15

  sequence s_hung;
    idle_exp && !sda_f;
  endsequence
  sequence s_first_pulse;
    ##1 scl_oe_o [*8] ##[1:600] !scl_oe_o;
  endsequence
  property p_clear;
    @(posedge ref_clk_i) disable iff (sys_rst_i)
      s_hung |-> s_first_pulse;
  endproperty
  a_clear: assert property (p_clear) else $error("hung bus not clocked"); // R16
endmodule : ccic_top
`default_nettype wire

// ===== ccic_far_model.sv
// ccic_far_model: far side of ccic_top, i2c wires with pull-ups and the serial link from the remote end
// assumes the bench calls its tasks; the link clock runs only inside a frame
`default_nettype none
module ccic_far_model (
  input  wire logic scl_oe_i,
  output logic      scl_o,
  output logic      sda_o,
  output logic      link_clk_o,
  output logic      link_err_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic sda_low = 1'b0;
  // pull-ups: a line that nobody pulls low reads high
  assign scl_o = !scl_oe_i;
  assign sda_o = !sda_low;
  initial link_clk_o = 1'b0;
  initial link_err_o = 1'b0;
  task automatic frame(input logic err);
    link_err_o = err;
    repeat (4) begin
      #80 link_clk_o = 1'b1;
      #80 link_clk_o = 1'b0;
    end
    // the error line is not held past the frame, so show the opposite level
    link_err_o = !err;
  endtask : frame
  task automatic glitch(input int ns);
    sda_low = 1'b1;
    #(ns) sda_low = 1'b0;
  endtask : glitch
endmodule : ccic_far_model
`default_nettype wire

// ===== control_channel_i2c_config_tb.sv
// control_channel_i2c_config_tb: self-checking bench for ccic_top; drivers queue expected reads and events
// assumes ccic_far_model for pins and link; long counts are shortened through parameters
`default_nettype none
module control_channel_i2c_config_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int UNIT = 20;
  localparam int FAST = 50;
  localparam int SLOW = 200;
  logic       clk      = 1'b0;
  logic       rst      = 1'b1;
  logic       wr;
  logic       rd;
  logic       rem;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic       sreq;
  logic       start;
  logic       done;
  logic [7:0] rdata;
  logic [8:0] dly;
  logic       refused, spass, abort, lclk, lerr, scl, sda, scl_drv, scl_oe, held, fwd, free, busy;
  logic [7:0] q_rd[$];
  logic [1:0] q_ev[$];
  int         n_fail   = 0;
  int         compares = 0;
  int         cyc      = 0;
  int         n_ev     = 0;
  int         t_ev     = 0;
  int         n_pul    = 0;
  int         n_low    = 0;
  logic       rd_d     = 1'b0;
  logic       oe_d     = 1'b0;

  always #5 clk = !clk;

  ccic_top #(.TXN_UNIT_CYC(UNIT), .BUS_FAST_CYC(FAST), .BUS_SLOW_CYC(SLOW)) dut (
    .ref_clk_i(clk), .sys_rst_i(rst), .reg_wr_i(wr), .reg_rd_i(rd), .reg_remote_i(rem),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .reg_wr_refused_o(refused),
    .remote_slave_req_i(sreq), .remote_slave_pass_o(spass), .txn_start_i(start), .txn_done_i(done),
    .txn_abort_o(abort), .link_clk_i(lclk), .link_seq_err_i(lerr), .scl_i(scl), .sda_i(sda),
    .scl_o(scl_drv), .scl_oe_o(scl_oe), .sda_held_o(held), .fwd_all_o(fwd),
    .sda_out_dly_ns_o(dly), .bus_free_o(free), .bus_clear_busy_o(busy));
  ccic_far_model far (.scl_oe_i(scl_oe), .scl_o(scl), .sda_o(sda), .link_clk_o(lclk), .link_err_o(lerr));

  task automatic results();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : results
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
    compares++;
    if (s !== e) begin
      n_fail++;
      $display("BAD %s expected %0h seen %0h", nm, e, s);
    end
  endtask : chk
  task automatic chk_rd(input logic [7:0] e, input logic [7:0] s);
    chk("reg_rdata_o", {8'h00, e}, {8'h00, s});
  endtask : chk_rd
  task automatic chk_ev(input logic [1:0] s);
    n_ev++;
    t_ev = cyc;
    chk("event", {14'h0, (q_ev.size() > 0) ? q_ev.pop_front() : 2'h0}, {14'h0, s});
  endtask : chk_ev

  // result watcher: a read answers one edge after it is taken, events are one-cycle pulses
  always @(posedge clk) begin
    cyc <= cyc + 1;
    rd_d <= rd;
    oe_d <= scl_oe;
    if (rd_d) chk_rd((q_rd.size() > 0) ? q_rd.pop_front() : 8'hXX, rdata);
    if (abort === 1'b1) chk_ev(2'h1);
    if (free === 1'b1) chk_ev(2'h2);
    if (refused === 1'b1) chk_ev(2'h3);
    if (scl_oe === 1'b1 && oe_d !== 1'b1) n_pul++;
    if (held === 1'b0) n_low++;
  end

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d, input logic r);
    @(posedge clk);
    wr <= 1'b1;
    rem <= r;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    rem <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    q_rd.push_back(e);
    @(posedge clk);
    rd <= 1'b0;
  endtask : rd_reg
  task automatic txn(input logic fin);
    @(posedge clk);
    start <= !fin;
    done <= fin;
    @(posedge clk);
    start <= 1'b0;
    done <= 1'b0;
  endtask : txn
  task automatic wait_ev(input int n0, input int lim);
    for (int i = 0; i < lim && n_ev == n0; i++) @(posedge clk);
    chk("event arrived", 16'h1, {15'h0, n_ev > n0});
  endtask : wait_ev
  task automatic quiet(input int n);
    int n0;
    n0 = n_ev;
    repeat (n) @(posedge clk);
    chk("no event", n0[15:0], n_ev[15:0]);
  endtask : quiet
  task automatic sda_delay(output int d);
    @(posedge clk);
    far.sda_low <= 1'b1;
    d = 0;
    while (held !== 1'b0 && d < 60) begin
      @(posedge clk);
      d++;
    end
    far.sda_low <= 1'b0;
    repeat (60) @(posedge clk);
  endtask : sda_delay

  initial begin
    logic [7:0] rv;
    int         d0, d2, n0, t0;
    void'($urandom(1641));
    wr <= 1'b0;
    rd <= 1'b0;
    rem <= 1'b0;
    addr <= 8'h00;
    wdata <= 8'h00;
    sreq <= 1'b0;
    start <= 1'b0;
    done <= 1'b0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rd_reg(ccic_pkg::ADDR_LINK_WD, 8'hFE);
    rd_reg(ccic_pkg::ADDR_I2C_TIME, 8'h1E);
    rd_reg(ccic_pkg::ADDR_I2C_PROT, 8'h00);
    rd_reg(8'h07, 8'h00);
    chk("fwd_all_o", 16'h0, {15'h0, fwd});
    // bus watchdog off so that idle-bus pulses stay out of the early tests
    wr_reg(ccic_pkg::ADDR_I2C_PROT, 8'h01, 1'b0);
    rv = 8'($urandom());
    wr_reg(ccic_pkg::ADDR_I2C_TIME, rv, 1'b0);
    rd_reg(ccic_pkg::ADDR_I2C_TIME, rv);
    chk("fwd_all_o", {15'h0, rv[7]}, {15'h0, fwd});
    for (int c = 0; c < 4; c++) begin
      wr_reg(ccic_pkg::ADDR_I2C_PROT, {3'h5, c[1:0], 3'h1}, 1'b0);
      rd_reg(ccic_pkg::ADDR_I2C_PROT, {3'h0, c[1:0], 3'h1});
      chk("sda_out_dly_ns_o", 16'(ccic_pkg::ODLY_BASE_NS + ccic_pkg::ODLY_STEP_NS * c), {7'h0, dly});
    end
    wr_reg(ccic_pkg::ADDR_I2C_PROT, 8'h05, 1'b0);
    q_ev.push_back(2'h3);
    n0 = n_ev;
    wr_reg(ccic_pkg::ADDR_I2C_TIME, 8'h80, 1'b1);
    wait_ev(n0, 4);
    rd_reg(ccic_pkg::ADDR_I2C_TIME, rv);
    wr_reg(ccic_pkg::ADDR_I2C_TIME, 8'h80, 1'b0);
    rd_reg(ccic_pkg::ADDR_I2C_TIME, 8'h80);
    @(posedge clk);
    sreq <= 1'b1;
    @(negedge clk);
    chk("remote_slave_pass_o", 16'h1, {15'h0, spass});
    wr_reg(ccic_pkg::ADDR_I2C_PROT, 8'h01, 1'b0);
    sreq <= 1'b0;
    wr_reg(ccic_pkg::ADDR_I2C_TIME, 8'h00, 1'b1);
    rd_reg(ccic_pkg::ADDR_I2C_TIME, 8'h00);
    far.frame(1'b1);
    repeat (8) @(posedge clk);
    rd_reg(ccic_pkg::ADDR_I2C_PROT, 8'h81);
    wr_reg(ccic_pkg::ADDR_I2C_PROT, 8'h41, 1'b0);
    rd_reg(ccic_pkg::ADDR_I2C_PROT, 8'h41);
    far.frame(1'b1);
    repeat (8) @(posedge clk);
    rd_reg(ccic_pkg::ADDR_I2C_PROT, 8'h41);
    wr_reg(ccic_pkg::ADDR_I2C_PROT, 8'h01, 1'b0);
    far.frame(1'b1);
    repeat (8) @(posedge clk);
    rd_reg(ccic_pkg::ADDR_I2C_PROT, 8'h81);
    wr_reg(ccic_pkg::ADDR_I2C_PROT, 8'h41, 1'b0);
    wr_reg(ccic_pkg::ADDR_I2C_PROT, 8'h01, 1'b0);
    far.frame(1'b0);
    repeat (8) @(posedge clk);
    rd_reg(ccic_pkg::ADDR_I2C_PROT, 8'h01);
    for (int t = 1; t < 4; t += 2) begin
      wr_reg(ccic_pkg::ADDR_LINK_WD, {t[6:0], 1'b0}, 1'b0);
      q_ev.push_back(2'h1);
      n0 = n_ev;
      txn(1'b0);
      t0 = cyc;
      wait_ev(n0, UNIT * t + 8);
      chk("abort delay", 16'h1, {15'h0, t_ev - t0 >= UNIT * t && t_ev - t0 <= UNIT * t + 3});
    end
    wr_reg(ccic_pkg::ADDR_LINK_WD, 8'h06, 1'b0);
    txn(1'b0);
    repeat (40) @(posedge clk);
    txn(1'b1);
    quiet(100);
    wr_reg(ccic_pkg::ADDR_LINK_WD, 8'h07, 1'b0);
    txn(1'b0);
    quiet(100);
    txn(1'b1);
    wr_reg(ccic_pkg::ADDR_I2C_TIME, 8'h00, 1'b0);
    sda_delay(d0);
    wr_reg(ccic_pkg::ADDR_I2C_TIME, 8'h20, 1'b0);
    sda_delay(d2);
    chk("hold delay", 16'hA, 16'(d2 - d0));
    wr_reg(ccic_pkg::ADDR_I2C_TIME, 8'h0E, 1'b0);
    n0 = n_low;
    far.glitch(40);
    repeat (30) @(posedge clk);
    chk("glitch rejected", n0[15:0], n_low[15:0]);
    wr_reg(ccic_pkg::ADDR_I2C_TIME, 8'h02, 1'b0);
    n0 = n_low;
    far.glitch(40);
    repeat (30) @(posedge clk);
    chk("pulse passed", 16'h1, {15'h0, n_low > n0});
    quiet(300);
    // sda edges restart the quiet timer, so each period is timed from the release
    for (int f = 0; f < 2; f++) begin
      q_ev.push_back(2'h2);
      @(posedge clk);
      far.sda_low <= 1'b1;
      wr_reg(ccic_pkg::ADDR_I2C_PROT, {6'h0, f[0], 1'b0}, 1'b0);
      repeat (8) @(posedge clk);
      far.sda_low <= 1'b0;
      n0 = n_ev;
      repeat (f ? 30 : 150) @(posedge clk);
      chk("no early free", n0[15:0], n_ev[15:0]);
      wait_ev(n0, 150);
      wr_reg(ccic_pkg::ADDR_I2C_PROT, 8'h01, 1'b0);
    end
    @(posedge clk);
    far.sda_low <= 1'b1;
    n0 = n_pul;
    wr_reg(ccic_pkg::ADDR_I2C_PROT, 8'h02, 1'b0);
    for (int i = 0; i < 200 && busy !== 1'b1; i++) @(posedge clk);
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk("scl pulled low", 16'h0, {15'h0, scl});
    chk("scl_o", 16'h0, {15'h0, scl_drv});
    for (int i = 0; i < 9500 && busy === 1'b1; i++) @(posedge clk);
    wr_reg(ccic_pkg::ADDR_I2C_PROT, 8'h01, 1'b0);
    chk("scl pulses", 16'h9, 16'(n_pul - n0));
    far.sda_low <= 1'b0;
    // second reset in mid-run: the link watchdog and protection registers must read back their reset values
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd_reg(ccic_pkg::ADDR_LINK_WD, 8'hFE);
    rd_reg(ccic_pkg::ADDR_I2C_PROT, 8'h00);
    repeat (60) @(posedge clk);
    chk("pending notes", 16'h0, 16'(q_rd.size() + q_ev.size()));
    results();
  end

  initial begin
    #400000;
    n_fail++;
    results();
  end
endmodule : control_channel_i2c_config_tb
`default_nettype wire
